// >>> txs_sonet_tx_byte_serializer.sv
// transmit byte serializer top: byte clock direction, capture and serial out
//
// Overview of operation
// RL1 - framer aligns bytes to our driven clock
// RL2 - serialize msb first, then descending bits
// RL3 - serial rate follows selected sonet rate
// RL4 - select high: drive byte clock per rate
// RL5 - output mode: capture byte on rising edge
// RL6 - select low: release pin, use as input
// RL7 - framer supplies matching byte clock, aligned data
// RL8 - input mode: latch byte on external edge
// RL9 - direction select defaults low, input mode
// RL10 - one byte per period, eight bits out
`timescale 1ns/1ps
`include "txs_regs.svh"

module txs_sonet_tx_byte_serializer (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic [`TXS_BYTE_W-1:0] tx_par_data,
  input  wire logic                   tx_clk_dir_sel,
  input  wire logic                   tx_rate_sel,
  input  wire logic                   tx_byte_clk_bidir_i,
  output logic                        tx_byte_clk_bidir_o,
  output logic                        tx_byte_clk_bidir_oe_n,
  output logic                        tx_serial_out_pos,
  output logic                        tx_serial_out_neg
);

  // pin synchronisers: first stage feeds only the second
  logic [`TXS_BYTE_W-1:0] dat_s1_q;
  logic [`TXS_BYTE_W-1:0] dat_s2_q;
  logic [`TXS_BYTE_W-1:0] dat_s3_q;
  logic                   sel_s1_q;
  logic                   sel_s2_q;
  logic                   rate_s1_q;
  logic                   rate_s2_q;
  logic                   rate_s3_q;
  logic                   bclk_s1_q;
  logic                   bclk_s2_q;
  logic                   bclk_s3_q;

  logic [`TXS_BYTE_W-1:0] dat_s1_d;
  logic [`TXS_BYTE_W-1:0] dat_s2_d;
  logic [`TXS_BYTE_W-1:0] dat_s3_d;
  logic                   sel_s1_d;
  logic                   sel_s2_d;
  logic                   rate_s1_d;
  logic                   rate_s2_d;
  logic                   rate_s3_d;
  logic                   bclk_s1_d;
  logic                   bclk_s2_d;
  logic                   bclk_s3_d;
  // each stage copies the one before it
  always_comb begin
    dat_s1_d  = tx_par_data;
    dat_s2_d  = dat_s1_q;
    dat_s3_d  = dat_s2_q;
    sel_s1_d  = tx_clk_dir_sel;
    sel_s2_d  = sel_s1_q;
    rate_s1_d = tx_rate_sel;
    rate_s2_d = rate_s1_q;
    rate_s3_d = rate_s2_q;
    bclk_s1_d = tx_byte_clk_bidir_i;
    bclk_s2_d = bclk_s1_q;
    bclk_s3_d = bclk_s2_q;
  end

  // rst clears every stage so no stale byte is loaded after reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dat_s1_q  <= 8'h00;
      dat_s2_q  <= 8'h00;
      dat_s3_q  <= 8'h00;
      // RL9 reset to input mode
      sel_s1_q  <= 1'b0;
      sel_s2_q  <= 1'b0;
      rate_s1_q <= 1'b0;
      rate_s2_q <= 1'b0;
      rate_s3_q <= 1'b0;
      bclk_s1_q <= 1'b0;
      bclk_s2_q <= 1'b0;
      bclk_s3_q <= 1'b0;
    end else begin
      dat_s1_q  <= dat_s1_d;
      dat_s2_q  <= dat_s2_d;
      dat_s3_q  <= dat_s3_d;
      sel_s1_q  <= sel_s1_d;
      sel_s2_q  <= sel_s2_d;
      rate_s1_q <= rate_s1_d;
      rate_s2_q <= rate_s2_d;
      rate_s3_q <= rate_s3_d;
      bclk_s1_q <= bclk_s1_d;
      bclk_s2_q <= bclk_s2_d;
      bclk_s3_q <= bclk_s3_d;
    end
  end

  // mode state and dividers
  txs_pkg::txs_mode_type mode_q;
  txs_pkg::txs_mode_type mode_d;
  logic [5:0]            bcnt_q;
  logic [5:0]            bcnt_d;
  logic [1:0]            bitcnt_q;
  logic [1:0]            bitcnt_d;
  logic                  clk_o_q;
  logic                  clk_o_d;
  logic                  oe_n_q;
  logic                  oe_n_d;
  logic [5:0]            byte_last;
  logic [5:0]            byte_half;
  logic [1:0]            bit_last;
  logic                  mode_chg;
  logic                  rate_chg;
  logic                  byte_wrap;
  logic                  bit_wrap;
  logic                  ext_rise;
  // shifter control travels as one packed struct
  txs_pkg::txs_shift_ctl_type ctl;

  // decode of the synchronised selects
  always_comb begin
    // RL3 rate picks both dividers
    byte_last = rate_s2_q ? `TXS_BYTE_FAST_LAST : `TXS_BYTE_SLOW_LAST;
    byte_half = rate_s2_q ? `TXS_BYTE_FAST_HALF : `TXS_BYTE_SLOW_HALF;
    bit_last  = rate_s2_q ? `TXS_BIT_FAST_LAST : `TXS_BIT_SLOW_LAST;
    byte_wrap = (bcnt_q >= byte_last);
    bit_wrap  = (bitcnt_q >= bit_last);
    // edge seen one stage early so the byte in dat_s3 predates it
    ext_rise  = bclk_s2_q & ~bclk_s3_q;
    mode_d    = sel_s2_q ? txs_pkg::TXS_MODE_OUT : txs_pkg::TXS_MODE_IN;
    mode_chg  = (mode_d != mode_q);
    // a rate change mid byte would otherwise cut a clock pulse short
    rate_chg  = (rate_s2_q != rate_s3_q);
  end

  // divider, byte clock and shifter control
  always_comb begin
    bcnt_d   = bcnt_q;
    bitcnt_d = bitcnt_q;
    clk_o_d  = clk_o_q;
    oe_n_d   = oe_n_q;
    ctl      = '0;
    unique case (mode_q)
      txs_pkg::TXS_MODE_OUT: begin
        // RL4 drive divided byte clock
        oe_n_d = 1'b0;
        if (byte_wrap) begin
          bcnt_d = `TXS_BYTE_CNT_ZERO;
        end else begin
          bcnt_d = bcnt_q + 6'h01;
        end
        // high half first so the rise lines up with count zero
        clk_o_d = (bcnt_d < byte_half);
        // RL5 capture at our rising edge
        ctl.load = (bcnt_q == `TXS_BYTE_CNT_ZERO);
        // RL1 byte settled before the edge
        ctl.data = dat_s2_q;
      end
      txs_pkg::TXS_MODE_IN: begin
        // limitation: a framer clock off the selected rate is not flagged
        // RL6 release pin, follow input
        oe_n_d  = 1'b1;
        clk_o_d = 1'b0;
        bcnt_d  = `TXS_BYTE_CNT_ZERO;
        // RL8 latch on external rising edge
        ctl.load = ext_rise;
        // RL7 value held just before edge
        ctl.data = dat_s3_q;
      end
    endcase
    // fast rate shifts every mclk, slow every fourth
    // RL10 eight bit slots per byte period
    if (ctl.load || bit_wrap) begin
      bitcnt_d = `TXS_BIT_CNT_ZERO;
    end else begin
      bitcnt_d = bitcnt_q + 2'h1;
    end
    ctl.bit_en = ~ctl.load && bit_wrap;
    // switching direction or rate restarts the byte timing cleanly;
    // parking at the last count makes the first pulse full width
    if (mode_chg || rate_chg) begin
      bcnt_d   = byte_last;
      bitcnt_d = `TXS_BIT_CNT_ZERO;
      clk_o_d  = 1'b0;
      oe_n_d   = (mode_d == txs_pkg::TXS_MODE_IN);
      ctl.load = 1'b0;
    end
  end

  // mode group registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_q   <= txs_pkg::TXS_MODE_IN;
      bcnt_q   <= `TXS_BYTE_CNT_ZERO;
      bitcnt_q <= `TXS_BIT_CNT_ZERO;
      clk_o_q  <= 1'b0;
      oe_n_q   <= 1'b1;
    end else begin
      mode_q   <= mode_d;
      bcnt_q   <= bcnt_d;
      bitcnt_q <= bitcnt_d;
      clk_o_q  <= clk_o_d;
      oe_n_q   <= oe_n_d;
    end
  end

  // RL2 shifter serializes each byte
  txs_par_to_ser_shifter u_shifter (
    .mclk    (mclk),
    .rst     (rst),
    .ctl     (ctl),
    .ser_pos (tx_serial_out_pos),
    .ser_neg (tx_serial_out_neg)
  );

  // pin drive and enable come straight from registers
  assign tx_byte_clk_bidir_o    = clk_o_q;
  assign tx_byte_clk_bidir_oe_n = oe_n_q;

endmodule : txs_sonet_tx_byte_serializer

// >>> txs_regs.svh
// constants for the sonet transmit byte serializer
`ifndef TXS_REGS_SVH
`define TXS_REGS_SVH

// byte width and the bit that leaves the shifter first
`define TXS_BYTE_W         8
`define TXS_MSB            7
`define TXS_SHIFT_LAST     3'h7

// documented line rates in kbit/s and byte clock rates in khz
`define TXS_SER_FAST_KBPS  32'h00097E00
`define TXS_SER_SLOW_KBPS  32'h00025F80
`define TXS_BCLK_FAST_KHZ  32'h00012FC0
`define TXS_BCLK_SLOW_KHZ  32'h00004BF0

// byte clock divider in mclk cycles: last count and high half
`define TXS_BYTE_FAST_LAST 6'h07
`define TXS_BYTE_SLOW_LAST 6'h1F
`define TXS_BYTE_FAST_HALF 6'h04
`define TXS_BYTE_SLOW_HALF 6'h10
`define TXS_BYTE_CNT_ZERO  6'h00

// serial bit divider: last count per rate
`define TXS_BIT_FAST_LAST  2'h0
`define TXS_BIT_SLOW_LAST  2'h3
`define TXS_BIT_CNT_ZERO   2'h0

`endif

// >>> txs_pkg.sv
// types shared by the transmit byte serializer files
package txs_pkg;

  typedef enum logic [1:0] {
    TXS_MODE_IN  = 2'b01,
    TXS_MODE_OUT = 2'b10
  } txs_mode_type;

  typedef struct packed {
    logic       load;
    logic       bit_en;
    logic [7:0] data;
  } txs_shift_ctl_type;

endpackage : txs_pkg

// >>> txs_par_to_ser_shifter.sv
// parallel to serial shifter, msb first, differential output
`timescale 1ns/1ps
`include "txs_regs.svh"

module txs_par_to_ser_shifter (
  input  wire logic                       mclk,
  input  wire logic                       rst,
  input  wire txs_pkg::txs_shift_ctl_type ctl,
  output logic                            ser_pos,
  output logic                            ser_neg
);

  logic [`TXS_BYTE_W-1:0] sr_q;
  logic [`TXS_BYTE_W-1:0] sr_d;
  logic [2:0]             cnt_q;
  logic [2:0]             cnt_d;
  logic                   pos_q;
  logic                   pos_d;
  logic                   neg_q;
  logic                   neg_d;

  always_comb begin
    sr_d  = sr_q;
    cnt_d = cnt_q;
    pos_d = pos_q;
    neg_d = neg_q;
    if (ctl.load) begin
      // RL2 msb first out
      sr_d  = ctl.data;
      cnt_d = 3'h0;
      pos_d = ctl.data[`TXS_MSB];
      neg_d = ~ctl.data[`TXS_MSB];
    end else if (ctl.bit_en && (cnt_q != `TXS_SHIFT_LAST)) begin
      // RL2 descending bit order
      sr_d  = {sr_q[`TXS_BYTE_W-2:0], 1'b0};
      cnt_d = cnt_q + 3'h1;
      pos_d = sr_q[`TXS_MSB-1];
      neg_d = ~sr_q[`TXS_MSB-1];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sr_q  <= 8'h00;
      cnt_q <= `TXS_SHIFT_LAST;
      pos_q <= 1'b0;
      neg_q <= 1'b1;
    end else begin
      sr_q  <= sr_d;
      cnt_q <= cnt_d;
      pos_q <= pos_d;
      neg_q <= neg_d;
    end
  end

  assign ser_pos = pos_q;
  assign ser_neg = neg_q;

endmodule : txs_par_to_ser_shifter

// >>> txs_checker.sv
// port assertions for the transmit byte serializer
`timescale 1ns/1ps
module txs_checker (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [7:0] tx_par_data,
  input wire logic       tx_clk_dir_sel,
  input wire logic       tx_rate_sel,
  input wire logic       tx_byte_clk_bidir_i,
  input wire logic       tx_byte_clk_bidir_o,
  input wire logic       tx_byte_clk_bidir_oe_n,
  input wire logic       tx_serial_out_pos,
  input wire logic       tx_serial_out_neg
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_fast_wave;
    tx_byte_clk_bidir_o [*4] ##1 !tx_byte_clk_bidir_o [*4] ##1 tx_byte_clk_bidir_o;
  endsequence
  sequence s_slow_wave;
    ##16 $fell(tx_byte_clk_bidir_o) ##16 $rose(tx_byte_clk_bidir_o);
  endsequence
  a_neg_inverse: assert property (tx_serial_out_neg != tx_serial_out_pos)
    else $error("serial pair not complementary");
  a_in_quiet: assert property (!tx_clk_dir_sel [*6] |-> tx_byte_clk_bidir_oe_n && !tx_byte_clk_bidir_o)
    else $error("byte clock driven in input mode");
  a_out_drive: assert property (tx_clk_dir_sel [*6] |-> !tx_byte_clk_bidir_oe_n)
    else $error("byte clock not driven");
  // raw select drops ahead of the synced mode, so it cuts off a switch in flight
  a_fast_wave: assert property (disable iff (rst || !tx_clk_dir_sel)
    $rose(tx_byte_clk_bidir_o) && tx_rate_sel |-> s_fast_wave) else $error("bad fast byte clock");
  a_slow_wave: assert property (disable iff (rst || !tx_clk_dir_sel)
    $rose(tx_byte_clk_bidir_o) && !tx_rate_sel |-> s_slow_wave) else $error("bad slow byte clock");
  a_fast_msb: assert property (disable iff (rst || !tx_clk_dir_sel)
    $rose(tx_byte_clk_bidir_o) && tx_rate_sel |=> tx_serial_out_pos == $past(tx_par_data[7], 2)
    ##1 tx_serial_out_pos == $past(tx_par_data[6], 3)) else $error("wrong first bits");
  a_slow_hold: assert property (disable iff (rst || !tx_clk_dir_sel)
    $rose(tx_byte_clk_bidir_o) && !tx_rate_sel |=> tx_serial_out_pos == $past(tx_par_data[7], 2)
    ##1 $stable(tx_serial_out_pos) [*3]) else $error("slow bit not held");
  a_in_capture: assert property (disable iff (rst || tx_clk_dir_sel)
    $rose(tx_byte_clk_bidir_i) && tx_byte_clk_bidir_oe_n |-> ##3 tx_serial_out_pos == $past(tx_par_data[7], 4))
    else $error("input mode capture wrong");
endmodule : txs_checker

bind txs_sonet_tx_byte_serializer txs_checker u_chk (
  .mclk                   (mclk),
  .rst                    (rst),
  .tx_par_data            (tx_par_data),
  .tx_clk_dir_sel         (tx_clk_dir_sel),
  .tx_rate_sel            (tx_rate_sel),
  .tx_byte_clk_bidir_i    (tx_byte_clk_bidir_i),
  .tx_byte_clk_bidir_o    (tx_byte_clk_bidir_o),
  .tx_byte_clk_bidir_oe_n (tx_byte_clk_bidir_oe_n),
  .tx_serial_out_pos      (tx_serial_out_pos),
  .tx_serial_out_neg      (tx_serial_out_neg)
);

// >>> txs_framer_model.sv
// framer stand-in: launches a new byte after each byte clock rise
`timescale 1ns/1ps
module txs_framer_model (
  input  wire logic       mclk,
  input  wire logic       pin,
  output logic      [7:0] data,
  output logic      [7:0] held,
  output logic            seen
);
  logic prev = 1'b0;
  initial data = 8'hC3;
  always @(negedge mclk) begin
    prev <= pin;
    seen <= pin & ~prev;
    if (pin && !prev) begin
      held <= data;
      data <= data + 8'h5B;
    end
  end
endmodule : txs_framer_model

// >>> txs_sonet_tx_byte_serializer_test.sv
// self-checking bench for the transmit byte serializer
`timescale 1ns/1ps
module txs_sonet_tx_byte_serializer_test;
  logic       mclk, rst, sel, rate, fr_clk, fr_en, clk_o, oe_n, pos, neg, seen;
  logic [7:0] data, held;
  int         errors, n_tests, cyc;
  // framer clock stands still unless fr_en is set and the device has released the pin
  wire        pin = oe_n ? (fr_en & fr_clk) : clk_o;

  txs_sonet_tx_byte_serializer u_dut (.mclk(mclk), .rst(rst), .tx_par_data(data), .tx_clk_dir_sel(sel),
    .tx_rate_sel(rate), .tx_byte_clk_bidir_i(pin), .tx_byte_clk_bidir_o(clk_o),
    .tx_byte_clk_bidir_oe_n(oe_n), .tx_serial_out_pos(pos), .tx_serial_out_neg(neg));
  txs_framer_model u_fr (.mclk(mclk), .pin(pin), .data(data), .held(held), .seen(seen));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    fr_clk = 1'b0;
    #25;
    forever #160 fr_clk = ~fr_clk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      final_report();
    end
  end

  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (exp !== got) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic stream(int lat, int slot);
    logic [7:0] exp;
    repeat (2) begin
      @(posedge seen);
      repeat (lat) @(negedge mclk);
      exp = held;
      for (int i = 7; i >= 0; i--) begin
        check("serial bit", 8'(exp[i]), 8'(pos));
        check("inverse bit", 8'(!exp[i]), 8'(neg));
        repeat (slot) @(negedge mclk);
      end
    end
  endtask : stream

  task automatic t_idle();
    repeat (10) @(negedge mclk);
    check("idle pin drive", 8'h01, 8'(oe_n));
    check("idle serial", 8'h01, {6'h00, clk_o, neg});
  endtask : t_idle

  task automatic t_out(logic fast, logic [7:0] per, int slot);
    time t0;
    rate = fast;
    sel = 1'b1;
    repeat (8) @(negedge mclk);
    check("pin drive", 8'h00, 8'(oe_n));
    @(posedge clk_o);
    t0 = $time;
    @(posedge clk_o);
    check("byte clock period", per, 8'(($time - t0) / 40));
    stream(1, slot);
  endtask : t_out

  task automatic t_in();
    sel = 1'b0;
    repeat (8) @(negedge mclk);
    check("pin released", 8'h02, {6'h00, oe_n, clk_o});
    @(negedge fr_clk);
    fr_en = 1'b1;
    stream(3, 1);
    @(negedge fr_clk);
    fr_en = 1'b0;
    @(negedge mclk);
  endtask : t_in

  task automatic final_report();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  initial begin
    rst = 1'b1;
    sel = 1'b0;
    rate = 1'b1;
    fr_en = 1'b0;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    t_idle();
    t_out(1'b1, 8'h08, 1);
    t_in();
    t_out(1'b0, 8'h20, 4);
    final_report();
  end
endmodule : txs_sonet_tx_byte_serializer_test
